/* File: hdl/atp_timer.sv */
`timescale 1ns/1ps
module atp_timer
    import atp_pkg::*;
#(
    parameter int PRE_W = 10
)
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Oscillator and port overrides
    input  wire logic        osc_in_pin,
    output logic             osc_pins_detached,
    // Compare output pin
    input  wire logic        compare_pin_dir,
    output logic             compare_out_level,
    output logic             compare_out_override,
    output logic             compare_out_oe,
    // Flags and vector acknowledges
    input  wire logic        compare_vec_taken,
    input  wire logic        overflow_vec_taken,
    output logic             compare_flag,
    output logic             overflow_flag
);

    typedef struct packed {
        logic                          sync1;
        logic                          sync2;
        logic                          sync3;
        logic                          osc_lvl;
        logic                          as_sel;
        logic [7:0]                    ctrl_tmp;
        logic [7:0]                    ctrl_act;
        logic [7:0]                    cnt_tmp;
        logic [7:0]                    cnt;
        logic [7:0]                    cmp_tmp;
        logic [7:0]                    cmp_buf;
        logic [7:0]                    cmp_act;
        logic [ATP_SLOTS-1:0]          pend;
        logic [ATP_SLOTS-1:0][1:0]     edges;
        logic                          psr;
        logic [PRE_W-1:0]              pre;
        logic                          up;
        logic                          block;
        logic                          oc;
        logic                          cmp_flag;
        logic                          ovf_flag;
        logic [31:0]                   prdata;
        logic                          pslverr;
    } atp_state_s;

    localparam atp_state_s ATP_RST_STATE = '0;

    atp_state_s r_ff;
    atp_state_s nxt_r;

    logic                 osc_rise;
    logic                 src_tick;
    logic                 tick;
    logic [PRE_W-1:0]     div_mask;
    logic [1:0]           wm;
    logic [1:0]           com;
    logic                 pwm;
    logic [7:0]           top;
    logic                 match;
    logic                 pwm_top;
    logic [ATP_SLOTS-1:0] done;
    logic                 wr;
    logic                 setup;
    logic [1:0]           new_wm;
    logic [1:0]           new_com;

    // Apply a compare action to the pin level
    function automatic logic com_act(input logic [1:0] mode, input logic cur);
        logic res;
        res = cur;
        unique case (mode)
            ATP_COM_OFF:    res = cur;
            ATP_COM_TOGGLE: res = ~cur;
            ATP_COM_CLEAR:  res = 1'b0;
            ATP_COM_SET:    res = 1'b1;
        endcase
        return res;
    endfunction

    assign wr    = psel && penable && pwrite;
    assign setup = psel && !penable;

    always_comb
    begin
        nxt_r = r_ff;

        // Oscillator pin passes three flops; an edge counts once stages two and three agree
        nxt_r.sync1 = osc_in_pin;
        nxt_r.sync2 = r_ff.sync1;
        nxt_r.sync3 = r_ff.sync2;
        osc_rise = (r_ff.sync2 == r_ff.sync3) && r_ff.sync2 && !r_ff.osc_lvl;
        if (r_ff.sync2 == r_ff.sync3)
        begin
            nxt_r.osc_lvl = r_ff.sync2;
        end

        src_tick = r_ff.as_sel ? osc_rise : 1'b1;

        // Prescaler clear; in async mode it waits for an oscillator edge
        if (r_ff.psr && (!r_ff.as_sel || osc_rise))
        begin
            nxt_r.pre = '0;
            nxt_r.psr = 1'b0;
        end
        else if (src_tick)
        begin
            nxt_r.pre = r_ff.pre + 1'b1;
        end

        unique case (r_ff.ctrl_act[ATP_CS_HI:0])
            3'h2:    div_mask = PRE_W'(10'h007);
            3'h3:    div_mask = PRE_W'(10'h01F);
            3'h4:    div_mask = PRE_W'(10'h03F);
            3'h5:    div_mask = PRE_W'(10'h07F);
            3'h6:    div_mask = PRE_W'(10'h0FF);
            3'h7:    div_mask = PRE_W'(10'h3FF);
            default: div_mask = '0;
        endcase
        tick = (r_ff.ctrl_act[ATP_CS_HI:0] != 3'h0) && src_tick
               && ((r_ff.pre & div_mask) == div_mask);

        wm  = {r_ff.ctrl_act[ATP_WM_HI_BIT], r_ff.ctrl_act[ATP_WM_LO_BIT]};
        com = r_ff.ctrl_act[ATP_COM_HI:ATP_COM_LO];
        pwm = (wm == ATP_WM_PC) || (wm == ATP_WM_FAST);
        top = (wm == ATP_WM_CLR) ? r_ff.cmp_act : ATP_MAX;

        // Compare on every tick; blocked after a counter write
        match   = tick && !r_ff.block && (r_ff.cnt == r_ff.cmp_act);
        pwm_top = pwm && com[1] && (r_ff.cmp_act == top);

        // Immediate compare update in normal and clear-on-match modes
        if (!pwm)
        begin
            nxt_r.cmp_act = r_ff.cmp_buf;
        end

        // Flag clears first so that a same-cycle set wins
        if (compare_vec_taken || (wr && paddr == ATP_OFF_FLAGS && pwdata[ATP_CMPF_BIT]))
        begin
            nxt_r.cmp_flag = 1'b0;
        end
        if (overflow_vec_taken || (wr && paddr == ATP_OFF_FLAGS && pwdata[ATP_OVFF_BIT]))
        begin
            nxt_r.ovf_flag = 1'b0;
        end

        if (tick)
        begin
            nxt_r.block = 1'b0;
            if (match)
            begin
                nxt_r.cmp_flag = 1'b1;
            end
            if (wm == ATP_WM_PC)
            begin
                if (r_ff.up)
                begin
                    if (r_ff.cnt == ATP_MAX)
                    begin
                        nxt_r.up  = 1'b0;
                        nxt_r.cnt = r_ff.cnt - 8'h01;
                        nxt_r.cmp_act = r_ff.cmp_buf;
                    end
                    else
                    begin
                        nxt_r.cnt = r_ff.cnt + 8'h01;
                    end
                end
                else if (r_ff.cnt == ATP_BOTTOM)
                begin
                    nxt_r.up  = 1'b1;
                    nxt_r.cnt = r_ff.cnt + 8'h01;
                    nxt_r.ovf_flag = 1'b1;
                end
                else
                begin
                    nxt_r.cnt = r_ff.cnt - 8'h01;
                end
                if (match && !pwm_top && com[1])
                begin
                    nxt_r.oc = r_ff.up ? com[0] : !com[0];
                end
            end
            else
            begin
                nxt_r.up  = 1'b1;
                nxt_r.cnt = (r_ff.cnt == top) ? ATP_BOTTOM : r_ff.cnt + 8'h01;
                if (r_ff.cnt == ATP_MAX)
                begin
                    nxt_r.ovf_flag = 1'b1;
                    if (wm == ATP_WM_FAST)
                    begin
                        nxt_r.cmp_act = r_ff.cmp_buf;
                    end
                end
                if (wm == ATP_WM_FAST)
                begin
                    // Match action, then BOTTOM action on the wrap
                    if (match && !pwm_top && com[1])
                    begin
                        nxt_r.oc = com[0];
                    end
                    if (r_ff.cnt == ATP_MAX && !pwm_top && com[1])
                    begin
                        nxt_r.oc = !com[0];
                    end
                end
                else if (match)
                begin
                    nxt_r.oc = com_act(com, r_ff.oc);
                end
            end
            // TOP carries the action in place of the match
            if (pwm_top && r_ff.cnt == top)
            begin
                nxt_r.oc = !com[0];
            end
        end

        // Holding-stage transfers, two oscillator edges in async mode
        for (int i = 0; i < ATP_SLOTS; i++)
        begin
            done[i] = 1'b0;
            if (r_ff.pend[i])
            begin
                if (!r_ff.as_sel || (osc_rise && r_ff.edges[i] == ATP_XFER_EDGES - 2'h1))
                begin
                    done[i]        = 1'b1;
                    nxt_r.pend[i]  = 1'b0;
                    nxt_r.edges[i] = 2'h0;
                end
                else if (osc_rise)
                begin
                    nxt_r.edges[i] = r_ff.edges[i] + 2'h1;
                end
            end
        end

        new_wm  = {r_ff.ctrl_tmp[ATP_WM_HI_BIT], r_ff.ctrl_tmp[ATP_WM_LO_BIT]};
        new_com = r_ff.ctrl_tmp[ATP_COM_HI:ATP_COM_LO];
        if (done[ATP_SLOT_CTRL])
        begin
            nxt_r.ctrl_act = r_ff.ctrl_tmp;
            nxt_r.ctrl_act[ATP_FORCE_BIT] = 1'b0;
            // Forced compare in non-PWM modes only; no flag, no clear
            if (r_ff.ctrl_tmp[ATP_FORCE_BIT]
                && (new_wm == ATP_WM_NORMAL || new_wm == ATP_WM_CLR))
            begin
                nxt_r.oc = com_act(new_com, r_ff.oc);
            end
        end
        if (done[ATP_SLOT_CNT])
        begin
            // Counter write blocks the following match
            nxt_r.cnt   = r_ff.cnt_tmp;
            nxt_r.block = 1'b1;
        end
        if (done[ATP_SLOT_CMP])
        begin
            nxt_r.cmp_buf = r_ff.cmp_tmp;
        end

        // APB writes take effect at the access edge
        if (wr)
        begin
            unique case (paddr)
                ATP_OFF_CTRL:
                begin
                    nxt_r.ctrl_tmp = pwdata[7:0];
                    nxt_r.pend[ATP_SLOT_CTRL]  = 1'b1;
                    nxt_r.edges[ATP_SLOT_CTRL] = 2'h0;
                end
                ATP_OFF_CNT:
                begin
                    nxt_r.cnt_tmp = pwdata[7:0];
                    nxt_r.pend[ATP_SLOT_CNT]  = 1'b1;
                    nxt_r.edges[ATP_SLOT_CNT] = 2'h0;
                end
                ATP_OFF_CMP:
                begin
                    nxt_r.cmp_tmp = pwdata[7:0];
                    nxt_r.pend[ATP_SLOT_CMP]  = 1'b1;
                    nxt_r.edges[ATP_SLOT_CMP] = 2'h0;
                end
                ATP_OFF_ASYNC:
                begin
                    nxt_r.as_sel = pwdata[ATP_AS_BIT];
                end
                ATP_OFF_SFR:
                begin
                    if (pwdata[ATP_PSR_BIT])
                    begin
                        nxt_r.psr = 1'b1;
                    end
                end
                default:
                begin
                end
            endcase
        end

        // Read data is captured in the setup cycle so it leaves a flop
        if (setup)
        begin
            nxt_r.prdata  = '0;
            nxt_r.pslverr = 1'b0;
            unique case (paddr)
                ATP_OFF_CTRL:
                begin
                    // Holding stage; force bit reads zero
                    nxt_r.prdata[7:0] = r_ff.ctrl_tmp;
                    nxt_r.prdata[ATP_FORCE_BIT] = 1'b0;
                end
                ATP_OFF_CNT:   nxt_r.prdata[7:0] = r_ff.cnt;
                ATP_OFF_CMP:   nxt_r.prdata[7:0] = r_ff.cmp_tmp;
                ATP_OFF_ASYNC:
                begin
                    nxt_r.prdata[ATP_AS_BIT] = r_ff.as_sel;
                    nxt_r.prdata[ATP_SLOTS-1:0] = r_ff.as_sel ? r_ff.pend : 3'h0;
                end
                ATP_OFF_SFR:   nxt_r.prdata[ATP_PSR_BIT] = r_ff.psr && r_ff.as_sel;
                ATP_OFF_FLAGS:
                begin
                    nxt_r.prdata[ATP_CMPF_BIT] = r_ff.cmp_flag;
                    nxt_r.prdata[ATP_OVFF_BIT] = r_ff.ovf_flag;
                end
                default:       nxt_r.pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r_ff <= ATP_RST_STATE;
        end
        else
        begin
            r_ff <= nxt_r;
        end
    end

    assign prdata  = r_ff.prdata;
    assign pready  = 1'b1;
    assign pslverr = r_ff.pslverr && psel && penable;

    // Pins detached while the oscillator is selected
    assign osc_pins_detached = r_ff.as_sel;

    // Override on nonzero mode; driver needs the direction bit too
    assign compare_out_override = |r_ff.ctrl_act[ATP_COM_HI:ATP_COM_LO];
    assign compare_out_oe       = compare_out_override && compare_pin_dir;
    assign compare_out_level    = r_ff.oc;
    assign compare_flag         = r_ff.cmp_flag;
    assign overflow_flag        = r_ff.ovf_flag;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_force_reads_zero: assert property (
        setup && paddr == ATP_OFF_CTRL |=> !prdata[ATP_FORCE_BIT])
        else $error("force strobe read back as one");

    a_sync_cnt_busy: assert property (
        wr && paddr == ATP_OFF_CNT && !r_ff.as_sel && !nxt_r.as_sel
        |=> r_ff.pend[ATP_SLOT_CNT] ##1 !r_ff.pend[ATP_SLOT_CNT])
        else $error("counter transfer did not complete in sync mode");

    a_cnt_xfer_value: assert property (
        $fell(r_ff.pend[ATP_SLOT_CNT]) |-> r_ff.cnt == $past(r_ff.cnt_tmp))
        else $error("counter transfer landed a wrong value");

    a_stopped_holds: assert property (
        r_ff.ctrl_act[ATP_CS_HI:0] == 3'h0 && !r_ff.pend[ATP_SLOT_CNT]
        |=> r_ff.cnt == $past(r_ff.cnt))
        else $error("counter moved while stopped");

    a_force_no_flag: assert property (
        done[ATP_SLOT_CTRL] && !match && !r_ff.cmp_flag |=> !r_ff.cmp_flag)
        else $error("forced compare set the compare flag");

    a_clr_wraps: assert property (
        wm == ATP_WM_CLR && tick && r_ff.cnt == r_ff.cmp_act && done == 3'h0
        |=> r_ff.cnt == ATP_BOTTOM)
        else $error("clear on match did not wrap to bottom");

    a_pc_ovf_bottom: assert property (
        wm == ATP_WM_PC && tick && !r_ff.up && r_ff.cnt == ATP_BOTTOM
        |=> r_ff.ovf_flag)
        else $error("phase-correct overflow missing at bottom");

    a_write_blocks: assert property (
        done[ATP_SLOT_CNT] && !r_ff.cmp_flag && !match && !(wr && paddr == ATP_OFF_CNT)
        && r_ff.cnt_tmp == r_ff.cmp_act ##1 tick && !r_ff.pend[ATP_SLOT_CNT]
        |=> !r_ff.cmp_flag)
        else $error("match not blocked after counter write");

    a_nonpwm_set: assert property (
        !pwm && match && com == ATP_COM_SET && done == 3'h0 |=> compare_out_level)
        else $error("set on match did not raise the pin");

endmodule

/* File: hdl/atp_pkg.sv */
package atp_pkg;

    // Register byte offsets on the APB bus
    localparam logic [7:0] ATP_OFF_CTRL  = 8'h00;
    localparam logic [7:0] ATP_OFF_CNT   = 8'h04;
    localparam logic [7:0] ATP_OFF_CMP   = 8'h08;
    localparam logic [7:0] ATP_OFF_ASYNC = 8'h0C;
    localparam logic [7:0] ATP_OFF_SFR   = 8'h10;
    localparam logic [7:0] ATP_OFF_FLAGS = 8'h14;

    // timer_control fields
    localparam int ATP_FORCE_BIT = 7;
    localparam int ATP_WM_HI_BIT = 6;
    localparam int ATP_COM_HI    = 5;
    localparam int ATP_COM_LO    = 4;
    localparam int ATP_WM_LO_BIT = 3;
    localparam int ATP_CS_HI     = 2;

    // async_status fields; busy bits double as the transfer slot index
    localparam int ATP_AS_BIT    = 3;
    localparam int ATP_SLOT_CNT  = 2;
    localparam int ATP_SLOT_CMP  = 1;
    localparam int ATP_SLOT_CTRL = 0;
    localparam int ATP_SLOTS     = 3;

    // special_function_reg and flag register fields
    localparam int ATP_PSR_BIT   = 1;
    localparam int ATP_CMPF_BIT  = 1;
    localparam int ATP_OVFF_BIT  = 0;

    // Oscillator edges a held write waits before landing
    localparam logic [1:0] ATP_XFER_EDGES = 2'h2;

    // Values after reset
    localparam logic [7:0] ATP_RST_BYTE = 8'h00;

    // Counter limits
    localparam logic [7:0] ATP_MAX    = 8'hFF;
    localparam logic [7:0] ATP_BOTTOM = 8'h00;

    // wave_mode encodings
    localparam logic [1:0] ATP_WM_NORMAL = 2'h0;
    localparam logic [1:0] ATP_WM_PC     = 2'h1;
    localparam logic [1:0] ATP_WM_CLR    = 2'h2;
    localparam logic [1:0] ATP_WM_FAST   = 2'h3;

    // compare_out_mode encodings
    localparam logic [1:0] ATP_COM_OFF    = 2'h0;
    localparam logic [1:0] ATP_COM_TOGGLE = 2'h1;
    localparam logic [1:0] ATP_COM_CLEAR  = 2'h2;
    localparam logic [1:0] ATP_COM_SET    = 2'h3;

endpackage

/* File: tb/atp_timer_test.sv */
`timescale 1ns/1ps
module atp_timer_test;
    import atp_pkg::*;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        osc_in_pin;
    logic        osc_pins_detached;
    logic        compare_pin_dir;
    logic        compare_out_level;
    logic        compare_out_override;
    logic        compare_out_oe;
    logic        compare_vec_taken;
    logic        overflow_vec_taken;
    logic        compare_flag;
    logic        overflow_flag;
    logic        osc_run;
    logic [3:0]  osc_div;
    logic [31:0] rd;
    logic        err;
    int          num_errors;
    int          cmp_count;
    int          cycles;

    atp_timer u_atp_timer (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .osc_in_pin, .osc_pins_detached, .compare_pin_dir,
        .compare_out_level, .compare_out_override, .compare_out_oe, .compare_vec_taken,
        .overflow_vec_taken, .compare_flag, .overflow_flag);

    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // Slow oscillator stands still unless a test runs it
    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (osc_run)
        begin
            osc_div <= osc_div + 4'h1;
            if (osc_div == 4'hF)
                osc_in_pin <= ~osc_in_pin;
        end
        if (cycles == 40000)
        begin
            num_errors = num_errors + 1;
            print_verdict();
        end
    end

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Every transfer opens on a fresh edge, so no signal is driven twice in a step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 100);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(name, rd, exp);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask

    function automatic logic [31:0] cw(logic [1:0] wm, logic [1:0] com, logic [2:0] cs,
                                       logic foc);
        cw = 32'h0000_0000;
        cw[ATP_FORCE_BIT] = foc;
        cw[ATP_WM_HI_BIT] = wm[1];
        cw[ATP_COM_HI:ATP_COM_LO] = com;
        cw[ATP_WM_LO_BIT] = wm[0];
        cw[ATP_CS_HI:0] = cs;
    endfunction

    task automatic t_reset;
        logic [7:0] offs [6] = '{ATP_OFF_CTRL, ATP_OFF_CNT, ATP_OFF_CMP, ATP_OFF_ASYNC,
                                 ATP_OFF_SFR, ATP_OFF_FLAGS};
        foreach (offs[i])
            rd_chk("reset value", offs[i], {24'h00_0000, ATP_RST_BYTE});
        apb(1'b1, 8'h18, 32'h0000_00FF);
        chk("unmapped slverr", err, 1'b1);
        chk("pready", pready, 1'b1);
        wait_cyc(1);
        chk("reset detach", osc_pins_detached, 1'b0);
        $display("t_reset done");
    endtask

    task automatic t_force;
        logic [1:0] com;
        logic       exp;
        exp = 1'b0;
        for (int i = 1; i < 4; i++)
        begin
            com = i[1:0];
            exp = (com == ATP_COM_TOGGLE) ? ~exp : com[0];
            apb(1'b1, ATP_OFF_CTRL, cw(ATP_WM_NORMAL, com, 3'h0, 1'b1));
            wait_cyc(2);
            chk("force level", compare_out_level, exp);
            rd_chk("force readback", ATP_OFF_CTRL, cw(ATP_WM_NORMAL, com, 3'h0, 1'b0));
        end
        wait_cyc(1);
        chk("override", compare_out_override, 1'b1);
        chk("oe off", compare_out_oe, 1'b0);
        @(posedge pclk);
        compare_pin_dir <= 1'b1;
        wait_cyc(1);
        chk("oe on", compare_out_oe, 1'b1);
        apb(1'b1, ATP_OFF_CNT, 32'h0000_0003);
        apb(1'b1, ATP_OFF_CTRL, cw(ATP_WM_CLR, ATP_COM_TOGGLE, 3'h0, 1'b1));
        wait_cyc(2);
        chk("clr force level", compare_out_level, 1'b0);
        chk("force no flag", compare_flag, 1'b0);
        rd_chk("force keeps count", ATP_OFF_CNT, 32'h0000_0003);
        $display("t_force done");
    endtask

    task automatic t_div;
        int          div [6] = '{8, 32, 64, 128, 256, 1024};
        logic [31:0] first;
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b1, ATP_OFF_CTRL, 32'h0000_0000);
            apb(1'b1, ATP_OFF_CNT, 32'h0000_0000);
            apb(1'b1, ATP_OFF_SFR, 32'h0000_0001 << ATP_PSR_BIT);
            apb(1'b1, ATP_OFF_CTRL, cw(ATP_WM_NORMAL, ATP_COM_OFF, 3'(i + 2), 1'b0));
            wait_cyc(4 * div[i]);
            apb(1'b0, ATP_OFF_CNT, 32'h0000_0000);
            chk("divided ticks", rd >= 3 && rd <= 5, 1'b1);
        end
        for (int s = 1; s >= 0; s--)
        begin
            apb(1'b1, ATP_OFF_CTRL, cw(ATP_WM_NORMAL, ATP_COM_OFF, 3'(s), 1'b0));
            apb(1'b0, ATP_OFF_CNT, 32'h0000_0000);
            first = rd;
            apb(1'b0, ATP_OFF_CNT, 32'h0000_0000);
            chk("tick step", rd - first, 32'(3 * s));
        end
        $display("t_div done");
    endtask

    task automatic t_ovf;
        for (int k = 0; k < 2; k++)
        begin
            apb(1'b1, ATP_OFF_CNT, 32'h0000_00FD);
            apb(1'b1, ATP_OFF_CTRL, cw(ATP_WM_NORMAL, ATP_COM_OFF, 3'h1, 1'b0));
            wait_cyc(8);
            apb(1'b1, ATP_OFF_CTRL, 32'h0000_0000);
            wait_cyc(1);
            chk("overflow set", overflow_flag, 1'b1);
            if (k == 0)
                apb(1'b1, ATP_OFF_FLAGS, 32'h0000_0001 << ATP_OVFF_BIT);
            else
            begin
                @(posedge pclk);
                overflow_vec_taken <= 1'b1;
                @(posedge pclk);
                overflow_vec_taken <= 1'b0;
            end
            wait_cyc(1);
            chk("overflow clear", overflow_flag, 1'b0);
        end
        $display("t_ovf done");
    endtask

    task automatic t_clr;
        apb(1'b1, ATP_OFF_CMP, 32'h0000_0005);
        apb(1'b1, ATP_OFF_CNT, 32'h0000_0000);
        apb(1'b1, ATP_OFF_FLAGS, 32'h0000_0003);
        apb(1'b1, ATP_OFF_CTRL, cw(ATP_WM_CLR, ATP_COM_TOGGLE, 3'h1, 1'b0));
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b0, ATP_OFF_CNT, 32'h0000_0000);
            chk("clr top", rd <= 5, 1'b1);
        end
        wait_cyc(300);
        chk("clr match flag", compare_flag, 1'b1);
        chk("clr no overflow", overflow_flag, 1'b0);
        apb(1'b1, ATP_OFF_CTRL, 32'h0000_0000);
        @(posedge pclk);
        compare_vec_taken <= 1'b1;
        @(posedge pclk);
        compare_vec_taken <= 1'b0;
        wait_cyc(1);
        chk("match flag vec clear", compare_flag, 1'b0);
        $display("t_clr done");
    endtask

    // Both PWM windows hold 768 high cycles for a mid-scale compare, 762 in phase-correct set mode
    task automatic t_pwm;
        int hi;
        int w;
        int ex;
        apb(1'b1, ATP_OFF_CTRL, 32'h0000_0000);
        apb(1'b1, ATP_OFF_CMP, 32'h0000_0080);
        for (int m = 0; m < 4; m++)
        begin
            w = (m < 2) ? 1536 : 1530;
            ex = m[0] ? w - 768 : 768;
            // Force strobe written as zero in PWM
            apb(1'b1, ATP_OFF_CTRL, cw(m < 2 ? ATP_WM_FAST : ATP_WM_PC,
                                       m[0] ? ATP_COM_SET : ATP_COM_CLEAR, 3'h1, 1'b0));
            wait_cyc(600);
            hi = 0;
            repeat (w)
            begin
                @(negedge pclk);
                hi += (compare_out_level === 1'b1);
            end
            chk("pwm duty", hi >= ex - 8 && hi <= ex + 8, 1'b1);
        end
        $display("t_pwm done");
    endtask

    task automatic t_async;
        logic [7:0]  offs [3] = '{ATP_OFF_CNT, ATP_OFF_CMP, ATP_OFF_CTRL};
        int          slot [3] = '{ATP_SLOT_CNT, ATP_SLOT_CMP, ATP_SLOT_CTRL};
        logic [31:0] val  [3] = '{32'h0000_0033, 32'h0000_0044, 32'h0000_0020};
        int          n;
        apb(1'b1, ATP_OFF_CTRL, 32'h0000_0000);
        apb(1'b1, ATP_OFF_ASYNC, 32'h0000_0001 << ATP_AS_BIT);
        osc_run <= 1'b1;
        wait_cyc(2);
        chk("detach", osc_pins_detached, 1'b1);
        // Rewrite all three after the switch
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, offs[i], val[i]);
            apb(1'b0, ATP_OFF_ASYNC, 32'h0000_0000);
            chk("busy set", rd[slot[i]], 1'b1);
            if (i > 0)
                rd_chk("held read", offs[i], val[i]);
            n = 0;
            do
            begin
                apb(1'b0, ATP_OFF_ASYNC, 32'h0000_0000);
                n++;
            end
            while (rd[slot[i]] !== 1'b0 && n < 100);
            chk("busy cleared", n < 100, 1'b1);
            rd_chk("landed", offs[i], val[i]);
        end
        apb(1'b1, ATP_OFF_ASYNC, 32'h0000_0000);
        wait_cyc(2);
        osc_run <= 1'b0;
        chk("reattach", osc_pins_detached, 1'b0);
        $display("t_async done");
    endtask

    initial
    begin
        presetn            = 1'b0;
        psel               = 1'b0;
        penable            = 1'b0;
        pwrite             = 1'b0;
        paddr              = 8'h00;
        pwdata             = 32'h0000_0000;
        osc_in_pin         = 1'b0;
        osc_run            = 1'b0;
        osc_div            = 4'h0;
        compare_pin_dir    = 1'b0;
        compare_vec_taken  = 1'b0;
        overflow_vec_taken = 1'b0;
        num_errors         = 0;
        cmp_count          = 0;
        cycles             = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_force();
        t_div();
        t_ovf();
        t_clr();
        t_pwm();
        t_async();
        print_verdict();
    end
endmodule
